// ---- hdl/aserc_top.sv ----
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module aserc_top #(
	parameter logic [15:0] CLKS_PER_BIT = aserc_pkg::DEF_CLKS_PER_BIT
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial line
	output logic txd,
	output logic tx_pin_en,
	input wire logic rxd,
	// interrupt
	output logic irq
);
	aserc_pkg::aserc_state_t s_ff;
	aserc_pkg::aserc_state_t nxt_s;
	logic do_wr;
	logic do_rd;
	logic [3:0] raddr;
	logic line;
	logic [3:0] frame_len;
	logic [15:0] quiet_tgt;
	logic [9:0] rx_sh_new;
	logic tc_set;
	logic tc_clr;
	logic irq_tx_empty;
	logic irq_tx_done;
	logic irq_rx_full;
	logic irq_quiet;
	logic rx_awake;
	logic tx_bit_end;
	logic rx_bit_end;
	logic rx_mid;
	logic brk_again;
	logic [3:0] brk_len;

	assign s_axi_awready = ce & ~s_ff.aw_hold & ~s_ff.bvalid;
	assign s_axi_wready = ce & ~s_ff.w_hold & ~s_ff.bvalid;
	assign s_axi_arready = ce & ~s_ff.rvalid;
	assign s_axi_bvalid = s_ff.bvalid;
	assign s_axi_bresp = s_ff.bresp;
	assign s_axi_rvalid = s_ff.rvalid;
	assign s_axi_rdata = s_ff.rdata_bus;
	assign s_axi_rresp = s_ff.rresp;
	assign txd = s_ff.ctl[aserc_pkg::TE_B] ? s_ff.txd : 1'b1; // [R5]
	assign tx_pin_en = s_ff.ctl[aserc_pkg::TE_B]; // [R5]
	assign irq_tx_empty = s_ff.ctl[aserc_pkg::TIE_B] & s_ff.fl.tx_buffer_empty; // [R1]
	assign irq_tx_done = s_ff.ctl[aserc_pkg::TX_DONE_IRQ_EN_B] & s_ff.fl.tc; // [R2]
	// receiver interrupts are held off while asleep
	assign rx_awake = ~s_ff.ctl[aserc_pkg::RWU_B]; // [R8]
	assign irq_rx_full = rx_awake & s_ff.ctl[aserc_pkg::RIE_B]
		& (s_ff.fl.rx_buffer_full | s_ff.fl.ovr); // [R3]
	assign irq_quiet = rx_awake & s_ff.ctl[aserc_pkg::LINE_QUIET_IRQ_EN_B] & s_ff.fl.idle; // [R4]
	assign irq = irq_tx_empty | irq_tx_done | irq_rx_full | irq_quiet; // [R24]

	// last cycle of a bit time on each side
	assign tx_bit_end = (s_ff.tx_cnt == CLKS_PER_BIT - 16'h0001);
	assign rx_bit_end = (s_ff.rx_cnt == CLKS_PER_BIT - 16'h0001);
	// the falling edge is seen a cycle late, so the wait to mid start bit is one short
	assign rx_mid = (s_ff.rx_cnt == (CLKS_PER_BIT >> 1) - 16'h0001);
	assign brk_len = (s_ff.long_brk ? aserc_pkg::LBREAK_BITS
		: aserc_pkg::BREAK_BITS) + {3'h0, s_ff.frame9}; // [R9]
	assign brk_again = (s_ff.txs == aserc_pkg::AS_TX_BRK)
		&& s_ff.ctl[aserc_pkg::SBK_B]; // [R10]

	always_comb begin
		nxt_s = s_ff;
		do_wr = 1'b0;
		do_rd = 1'b0;
		raddr = s_axi_araddr[3:0];
		line = s_ff.rx_m2;
		frame_len = aserc_pkg::FRAME_BITS + {3'h0, s_ff.frame9}; // [R23]
		quiet_tgt = 16'(CLKS_PER_BIT * {12'h000, frame_len});
		rx_sh_new = {line, s_ff.rx_sh[9:1]};
		tc_set = 1'b0;
		tc_clr = 1'b0;

		// pin synchroniser
		nxt_s.rx_m1 = rxd;
		nxt_s.rx_m2 = s_ff.rx_m1;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_s.aw_hold = 1'b1;
			nxt_s.awaddr = s_axi_awaddr[3:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_s.w_hold = 1'b1;
			nxt_s.wdata = s_axi_wdata;
			nxt_s.wstrb0 = s_axi_wstrb[0];
		end
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		if (s_ff.aw_hold && s_ff.w_hold && !s_ff.bvalid) begin
			do_wr = 1'b1;
			nxt_s.aw_hold = 1'b0;
			nxt_s.w_hold = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = aserc_pkg::RESP_OKAY;
			if (s_ff.awaddr[1:0] != 2'h0) begin
				nxt_s.bresp = aserc_pkg::RESP_SLVERR;
			end
		end
		if (do_wr && s_ff.wstrb0) begin
			unique case (s_ff.awaddr)
				aserc_pkg::CTL2_OFS: begin
					nxt_s.ctl = s_ff.wdata[7:0];
				end
				aserc_pkg::STAT1_OFS: begin
					// status writes are accepted and dropped [R12]
				end
				aserc_pkg::DATAL_OFS: begin
					nxt_s.tdata[7:0] = s_ff.wdata[7:0];
					nxt_s.arm.tx_buffer_empty = 1'b0;
					nxt_s.arm.tc = 1'b0;
					if (s_ff.arm.tx_buffer_empty) begin
						nxt_s.fl.tx_buffer_empty = 1'b0; // [R11] [R14]
					end
					if (s_ff.arm.tc) begin
						tc_clr = 1'b1; // [R16]
					end
				end
				aserc_pkg::CFG_OFS: begin
					nxt_s.frame9 = s_ff.wdata[aserc_pkg::M9_B];
					nxt_s.long_brk = s_ff.wdata[aserc_pkg::LBRK_B];
					nxt_s.tdata[8] = s_ff.wdata[aserc_pkg::TX8_B];
				end
				default: begin
				end
			endcase
		end

		// read channel
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			do_rd = 1'b1;
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = aserc_pkg::RESP_OKAY;
			nxt_s.rdata_bus = 32'h0000_0000;
			unique case (raddr)
				aserc_pkg::CTL2_OFS: begin
					nxt_s.rdata_bus[7:0] = s_ff.ctl;
				end
				aserc_pkg::STAT1_OFS: begin
					nxt_s.rdata_bus[7:3] = s_ff.fl;
					nxt_s.arm = s_ff.fl; // [R11]
				end
				aserc_pkg::DATAL_OFS: begin
					nxt_s.rdata_bus[7:0] = s_ff.rdata[7:0];
					nxt_s.arm.rx_buffer_full = 1'b0;
					nxt_s.arm.idle = 1'b0;
					nxt_s.arm.ovr = 1'b0;
					if (s_ff.arm.rx_buffer_full) begin
						nxt_s.fl.rx_buffer_full = 1'b0; // [R18]
					end
					if (s_ff.arm.idle) begin
						nxt_s.fl.idle = 1'b0;
					end
					if (s_ff.arm.ovr) begin
						nxt_s.fl.ovr = 1'b0;
					end
				end
				aserc_pkg::CFG_OFS: begin
					nxt_s.rdata_bus[aserc_pkg::M9_B] = s_ff.frame9;
					nxt_s.rdata_bus[aserc_pkg::LBRK_B] = s_ff.long_brk;
					nxt_s.rdata_bus[aserc_pkg::TX8_B] = s_ff.tdata[8];
					nxt_s.rdata_bus[aserc_pkg::RX8_B] = s_ff.rdata[8];
				end
				default: begin
					nxt_s.rresp = aserc_pkg::RESP_SLVERR;
				end
			endcase
			if (s_axi_araddr[1:0] != 2'h0) begin
				nxt_s.rresp = aserc_pkg::RESP_SLVERR;
			end
		end

		// transmitter
		nxt_s.tx_on_d = s_ff.ctl[aserc_pkg::TE_B];
		if (s_ff.ctl[aserc_pkg::TE_B] && !s_ff.tx_on_d) begin
			nxt_s.pre_pend = 1'b1; // [R6]
		end
		if (!s_ff.ctl[aserc_pkg::TE_B]) begin
			nxt_s.txs = aserc_pkg::AS_TX_IDLE; // [R5]
			nxt_s.pre_pend = 1'b0;
			nxt_s.txd = 1'b1;
		end else if (s_ff.txs == aserc_pkg::AS_TX_IDLE) begin
			nxt_s.tx_cnt = 16'h0000;
			nxt_s.tx_left = frame_len;
			if (s_ff.ctl[aserc_pkg::SBK_B]) begin
				// re-entered each time while the bit stays set [R9] [R10]
				nxt_s.txs = aserc_pkg::AS_TX_BRK;
				nxt_s.tx_sh = 12'h000;
				nxt_s.tx_left = brk_len; // [R9]
				tc_clr = 1'b1; // [R16]
			end else if (s_ff.pre_pend) begin
				nxt_s.txs = aserc_pkg::AS_TX_PRE;
				nxt_s.pre_pend = 1'b0;
				nxt_s.tx_sh = 12'hFFF;
				tc_clr = 1'b1; // [R16]
			end else if (!s_ff.fl.tx_buffer_empty) begin
				nxt_s.txs = aserc_pkg::AS_TX_DATA;
				nxt_s.tx_sh = {2'h3, s_ff.frame9 ? s_ff.tdata[8] : 1'b1,
					s_ff.tdata[7:0], 1'b0};
				nxt_s.fl.tx_buffer_empty = 1'b1; // [R13]
				tc_clr = 1'b1; // [R16]
			end else begin
				tc_set = 1'b1; // [R15]
			end
			nxt_s.txd = nxt_s.tx_sh[0];
			if (nxt_s.txs == aserc_pkg::AS_TX_IDLE) begin
				nxt_s.txd = 1'b1; // [R15]
			end
		end else begin
			nxt_s.tx_cnt = s_ff.tx_cnt + 16'h0001;
			if (tx_bit_end) begin
				nxt_s.tx_cnt = 16'h0000;
				nxt_s.tx_sh = {1'b1, s_ff.tx_sh[11:1]};
				nxt_s.tx_left = s_ff.tx_left - 4'h1;
				nxt_s.txd = nxt_s.tx_sh[0];
				// the shifter is shorter than a long break, so a break drives zero itself
				if (s_ff.txs == aserc_pkg::AS_TX_BRK) begin
					nxt_s.txd = 1'b0; // [R9]
				end
				if (s_ff.tx_left == 4'h1) begin
					nxt_s.txs = aserc_pkg::AS_TX_IDLE;
					nxt_s.txd = 1'b1;
					// a held break_send restarts at once, no high bit between breaks
					if (brk_again) begin
						nxt_s.txs = aserc_pkg::AS_TX_BRK; // [R10]
						nxt_s.tx_left = brk_len;
						nxt_s.txd = 1'b0;
					end
				end
			end
		end
		// a clear in the same cycle as a set leaves the flag low
		if (tc_set) begin
			nxt_s.fl.tc = 1'b1;
		end
		if (tc_clr) begin
			nxt_s.fl.tc = 1'b0; // [R17]
		end

		// receiver
		if (!s_ff.ctl[aserc_pkg::RE_B]) begin
			nxt_s.rxs = aserc_pkg::AS_RX_IDLE; // [R7]
			nxt_s.rx_cnt = 16'h0000;
		end else begin
			unique case (s_ff.rxs)
				aserc_pkg::AS_RX_IDLE: begin
					nxt_s.rx_cnt = 16'h0000;
					if (!line) begin
						nxt_s.rxs = aserc_pkg::AS_RX_START;
					end
				end
				aserc_pkg::AS_RX_START: begin
					nxt_s.rx_cnt = s_ff.rx_cnt + 16'h0001;
					if (rx_mid) begin
						nxt_s.rx_cnt = 16'h0000;
						nxt_s.rx_left = frame_len - 4'h1;
						// a glitch shorter than half a bit is no start
						nxt_s.rxs = line ? aserc_pkg::AS_RX_IDLE : aserc_pkg::AS_RX_DATA;
					end
				end
				aserc_pkg::AS_RX_DATA: begin
					nxt_s.rx_cnt = s_ff.rx_cnt + 16'h0001;
					if (rx_bit_end) begin
						nxt_s.rx_cnt = 16'h0000;
						nxt_s.rx_sh = rx_sh_new;
						nxt_s.rx_left = s_ff.rx_left - 4'h1;
						if (s_ff.rx_left == 4'h1) begin
							nxt_s.rxs = aserc_pkg::AS_RX_IDLE;
							if (!s_ff.ctl[aserc_pkg::RWU_B]) begin // [R8]
								if (s_ff.fl.rx_buffer_full) begin
									nxt_s.fl.ovr = 1'b1; // [R22]
								end else begin
									nxt_s.rdata = s_ff.frame9 ? rx_sh_new[8:0]
										: {1'b0, rx_sh_new[8:1]}; // [R23]
									nxt_s.fl.rx_buffer_full = 1'b1; // [R18]
									nxt_s.idle_ok = 1'b1; // [R20]
								end
							end
						end
					end
				end
				default: begin
					nxt_s.rxs = aserc_pkg::AS_RX_IDLE;
				end
			endcase
		end

		// idle line: a run of ones as long as one frame
		if (!s_ff.ctl[aserc_pkg::RE_B] || !line) begin
			nxt_s.quiet = 16'h0000;
		end else if (s_ff.quiet != quiet_tgt) begin
			nxt_s.quiet = s_ff.quiet + 16'h0001;
			if (s_ff.quiet == quiet_tgt - 16'h0001) begin
				if (s_ff.ctl[aserc_pkg::RWU_B]) begin
					nxt_s.ctl[aserc_pkg::RWU_B] = 1'b0; // [R8] [R21]
				end else if (s_ff.idle_ok) begin
					nxt_s.fl.idle = 1'b1; // [R19]
					nxt_s.idle_ok = 1'b0; // [R20]
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
			s_ff.ctl <= aserc_pkg::CTL2_RST;
			s_ff.fl.tx_buffer_empty <= 1'b1;
			s_ff.fl.tc <= 1'b1;
			s_ff.txs <= aserc_pkg::AS_TX_IDLE;
			s_ff.txd <= 1'b1;
			s_ff.rxs <= aserc_pkg::AS_RX_IDLE;
			s_ff.rx_m1 <= 1'b1;
			s_ff.rx_m2 <= 1'b1;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end
endmodule // aserc_top

// ---- pkg/aserc_pkg.sv ----
// Functional notes
// R1 - tx empty flag requests irq when enabled
// R2 - tx done flag requests irq when enabled
// R3 - rx full or overrun request irq when enabled
// R4 - idle flag requests irq when enabled
// R5 - tx_on enables transmitter, owns tx pin
// R6 - setting tx_on queues an idle preamble
// R7 - rx_on enables the receiver
// R8 - rx_sleep: standby, wakeup, rx irqs masked
// R9 - toggling break_send sends one break character
// R10 - break_send held sends breaks back to back
// R11 - software clears flags: status read, data access
// R12 - status register writes change nothing
// R13 - tx empty sets when shifter takes byte
// R14 - tx empty clears by status read, data write
// R15 - tx done low while sending, high when idle
// R16 - tx done clears by sequence or queueing
// R17 - tx done: clear beats simultaneous set
// R18 - rx full sets on transfer, clears by sequence
// R19 - idle sets after 10 or 11 ones
// R20 - idle rearms only after a new frame
// R21 - no idle flag while rx_sleep set
// R22 - overrun on second stop bit, data kept; the code sets it at the mid-bit sample of the frame's only stop bit
// R23 - frame is 8 or 9 data bits
// R24 - one irq output, OR of enabled flags
package aserc_pkg;
	localparam logic [3:0] CTL2_OFS = 4'h0;
	localparam logic [3:0] STAT1_OFS = 4'h4;
	localparam logic [3:0] DATAL_OFS = 4'h8;
	localparam logic [3:0] CFG_OFS = 4'hC;
	// control_two_reg bit positions
	localparam int TIE_B = 7;
	localparam int TX_DONE_IRQ_EN_B = 6;
	localparam int RIE_B = 5;
	localparam int LINE_QUIET_IRQ_EN_B = 4;
	localparam int TE_B = 3;
	localparam int RE_B = 2;
	localparam int RWU_B = 1;
	localparam int SBK_B = 0;
	// config register: frame9, long break, tx ninth bit, rx ninth bit
	localparam int M9_B = 0;
	localparam int LBRK_B = 1;
	localparam int TX8_B = 2;
	localparam int RX8_B = 3;
	localparam logic [7:0] CTL2_RST = 8'h00;
	localparam logic [3:0] FRAME_BITS = 4'hA;
	localparam logic [3:0] BREAK_BITS = 4'hA;
	localparam logic [3:0] LBREAK_BITS = 4'hD;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [15:0] DEF_CLKS_PER_BIT = 16'h0010;

	typedef enum logic [3:0] {
		AS_TX_IDLE = 4'h1,
		AS_TX_PRE = 4'h2,
		AS_TX_BRK = 4'h4,
		AS_TX_DATA = 4'h8
	} aserc_tx_st_t;

	typedef enum logic [2:0] {
		AS_RX_IDLE = 3'h1,
		AS_RX_START = 3'h2,
		AS_RX_DATA = 3'h4
	} aserc_rx_st_t;

	// flags that a status read arms for clearing
	typedef struct packed {
		logic tx_buffer_empty;
		logic tc;
		logic rx_buffer_full;
		logic idle;
		logic ovr;
	} aserc_flags_t;

	typedef struct packed {
		logic [7:0] ctl;
		logic frame9;
		logic long_brk;
		logic [8:0] tdata;
		aserc_flags_t fl;
		aserc_flags_t arm;
		logic pre_pend;
		logic tx_on_d;
		aserc_tx_st_t txs;
		logic [11:0] tx_sh;
		logic [3:0] tx_left;
		logic [15:0] tx_cnt;
		logic txd;
		logic idle_ok;
		logic [8:0] rdata;
		aserc_rx_st_t rxs;
		logic [9:0] rx_sh;
		logic [3:0] rx_left;
		logic [15:0] rx_cnt;
		logic [15:0] quiet;
		logic rx_m1;
		logic rx_m2;
		logic aw_hold;
		logic [3:0] awaddr;
		logic w_hold;
		logic [31:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata_bus;
		logic [1:0] rresp;
	} aserc_state_t;
endpackage

// ---- verification/aserc_monitor.sv ----
`timescale 1ns/10ps
module aserc_monitor #(
	parameter logic [15:0] CLKS_PER_BIT = 16'h0010
) (
	// clock, reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial line
	input wire logic txd,
	input wire logic tx_pin_en
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// length of the current low run on the line
	logic [15:0] low_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || txd) begin
			low_ff <= 16'h0000;
		end else begin
			low_ff <= low_ff + 16'h0001;
		end
	end
	txd_idle_a: assert property (!tx_pin_en |-> txd)
		else $error("line low while transmitter off");
	pin_write_a: assert property ($changed(tx_pin_en) |-> ##[0:2] s_axi_bvalid)
		else $error("pin ownership changed without a write");
	preamble_high_a: assert property ($rose(tx_pin_en) |-> txd [*8])
		else $error("no idle preamble after enable");
	bit_length_a: assert property ($rose(txd) && tx_pin_en |-> low_ff % CLKS_PER_BIT == 0)
		else $error("low run not whole bit times");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address accepted during response");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted during response");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
endmodule // aserc_monitor

bind aserc_top aserc_monitor #(.CLKS_PER_BIT(CLKS_PER_BIT)) i_mon (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .txd(txd), .tx_pin_en(tx_pin_en));

// ---- verification/aserc_remote.sv ----
`timescale 1ns/10ps
module aserc_remote #(
	parameter int CPB = 4
) (
	// clock
	input wire logic aclk,
	// serial lines
	input wire logic txd,
	input wire logic tx_pin_en,
	output logic rxd
);
	logic [8:0] sh;
	logic [7:0] got;
	int frames = 0;
	int run = 0;
	int brk_len = 0;
	int brk_cnt = 0;
	initial begin
		rxd = 1'b1;
		forever begin
			@(negedge txd);
			if (tx_pin_en === 1'b1) begin
				repeat (CPB / 2) @(posedge aclk);
				for (int i = 0; i < 9; i++) begin
					repeat (CPB) @(posedge aclk);
					sh[i] = txd;
				end
				// a zero stop bit is a break, not a frame
				if (sh[8]) begin
					got = sh[7:0];
					frames++;
				end
			end
		end
	end
	// any low run longer than a frame of zeros counts as a break
	always @(posedge aclk) begin
		if (txd === 1'b0) begin
			run <= run + 1;
		end else begin
			if (run > 9 * CPB) begin
				brk_len <= run;
				brk_cnt <= brk_cnt + 1;
			end
			run <= 0;
		end
	end
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge aclk);
			rxd <= f[i];
			repeat (CPB - 1) @(posedge aclk);
		end
	endtask
endmodule // aserc_remote

// ---- verification/aserc_top_test.sv ----
`timescale 1ns/10ps
module aserc_top_test;
	localparam int CPB = 4;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic txd, tx_pin_en, rxd, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, br;
	logic [7:0] b;
	int failures = 0, total_checks = 0, cycles = 0, seed = 32'h5AB6, k;
	always #12.5 aclk = ~aclk;
	aserc_top #(.CLKS_PER_BIT(16'h0004)) i_dut (.aclk, .aresetn, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .txd, .tx_pin_en, .rxd, .irq);
	aserc_remote #(.CPB(CPB)) i_rem (.aclk, .txd, .tx_pin_en, .rxd);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// readies are combinational of registered state, so the half cycle shows the edge value
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic at, wt, bt;
		@(posedge aclk);
		s_axi_awaddr <= {28'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			at = s_axi_awvalid & s_axi_awready;
			wt = s_axi_wvalid & s_axi_wready;
			bt = s_axi_bvalid;
			br = s_axi_bresp;
			@(posedge aclk);
			if (at) s_axi_awvalid <= 1'b0;
			if (wt) s_axi_wvalid <= 1'b0;
		end while (bt !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic at, rt;
		@(posedge aclk);
		s_axi_araddr <= {28'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			at = s_axi_arvalid & s_axi_arready;
			rt = s_axi_rvalid;
			d = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (at) s_axi_arvalid <= 1'b0;
		end while (rt !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] m, e);
		rd(a, v, r);
		chk(n, e, v & m);
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("control", aserc_pkg::CTL2_OFS, 32'hFFFFFFFF, {24'h0, aserc_pkg::CTL2_RST});
		rchk("status", aserc_pkg::STAT1_OFS, 32'hFFFFFFFF, 32'hC0);
		rd(4'h2, v, r);
		chk("resp", {30'h0, aserc_pkg::RESP_SLVERR}, {30'h0, r});
		wr(4'h6, 32'h0);
		chk("wresp", {30'h0, aserc_pkg::RESP_SLVERR}, {30'h0, br});
		wr(aserc_pkg::STAT1_OFS, 32'h0);
		rchk("status kept", aserc_pkg::STAT1_OFS, 32'hFF, 32'hC0);
		// last step leaves only the transmitter on
		for (int i = 0; i < 5; i++) begin
			wr(aserc_pkg::CTL2_OFS, 32'h80 >> i);
			@(negedge aclk);
			chk("irq", {31'h0, i < 2}, {31'h0, irq});
		end
		chk("pin owner", 32'h1, {31'h0, tx_pin_en});
		// with the clock enable low no request may be taken
		@(posedge aclk);
		ce <= 1'b0;
		repeat (2) @(negedge aclk);
		chk("ready frozen", 32'h0, {31'h0, s_axi_arready | s_axi_awready | s_axi_wready});
		@(posedge aclk);
		ce <= 1'b1;
		$display("test control done");
		for (int i = 0; i < 3; i++) begin
			b = 8'($random(seed));
			k = i_rem.frames;
			rchk("empty", aserc_pkg::STAT1_OFS, 32'h80, 32'h80);
			wr(aserc_pkg::DATAL_OFS, {24'h0, b});
			rchk("done low", aserc_pkg::STAT1_OFS, 32'h40, 32'h0);
			for (int n = 0; n < 400 && i_rem.frames == k; n++) @(posedge aclk);
			chk("tx byte", {24'h0, b}, {24'h0, i_rem.got});
		end
		repeat (4 * CPB) @(posedge aclk);
		rchk("tx idle", aserc_pkg::STAT1_OFS, 32'hC0, 32'hC0);
		// the last pass leaves frame9 clear for the receive tests
		for (int i = 3; i >= 0; i--) begin
			wr(aserc_pkg::CFG_OFS, 32'(i));
			k = i_rem.brk_cnt;
			wr(aserc_pkg::CTL2_OFS, 32'h09);
			wr(aserc_pkg::CTL2_OFS, 32'h08);
			for (int n = 0; n < 400 && i_rem.brk_cnt == k; n++) @(posedge aclk);
			repeat (20 * CPB) @(posedge aclk);
			chk("break length", (((i & 2) ? 13 : 10) + (i & 1)) * CPB, i_rem.brk_len);
			chk("break count", k + 1, i_rem.brk_cnt);
		end
		$display("test transmit done");
		wr(aserc_pkg::CTL2_OFS, 32'h24);
		b = 8'($random(seed));
		i_rem.send(b);
		for (int n = 0; n < 400 && irq !== 1'b1; n++) @(negedge aclk);
		chk("rx irq", 32'h1, {31'h0, irq});
		rchk("rx full", aserc_pkg::STAT1_OFS, 32'h20, 32'h20);
		rchk("rx data", aserc_pkg::DATAL_OFS, 32'hFF, {24'h0, b});
		rchk("rx cleared", aserc_pkg::STAT1_OFS, 32'h20, 32'h0);
		repeat (12 * CPB) @(posedge aclk);
		rchk("idle set", aserc_pkg::STAT1_OFS, 32'h10, 32'h10);
		rd(aserc_pkg::DATAL_OFS, v, r);
		repeat (12 * CPB) @(posedge aclk);
		rchk("idle rearm", aserc_pkg::STAT1_OFS, 32'h10, 32'h0);
		i_rem.send(b);
		i_rem.send(~b);
		repeat (2 * CPB) @(posedge aclk);
		rchk("overrun", aserc_pkg::STAT1_OFS, 32'h28, 32'h28);
		rchk("kept data", aserc_pkg::DATAL_OFS, 32'hFF, {24'h0, b});
		repeat (12 * CPB) @(posedge aclk);
		wr(aserc_pkg::CTL2_OFS, 32'h16);
		i_rem.send(~b);
		repeat (2 * CPB) @(posedge aclk);
		@(negedge aclk);
		chk("sleep irq", 32'h0, {31'h0, irq});
		rchk("discarded", aserc_pkg::STAT1_OFS, 32'h20, 32'h0);
		repeat (12 * CPB) @(posedge aclk);
		rchk("woken", aserc_pkg::CTL2_OFS, 32'h02, 32'h0);
		$display("test receive done");
		print_verdict();
	end
endmodule // aserc_top_test
